// file: src/uet_uart_regs.vh
`ifndef UET_UART_REGS_VH
`define UET_UART_REGS_VH
// ************************************************************
// Register offsets (byte addresses)
// ************************************************************
`define UET_OFS_MODE      8'h00
`define UET_OFS_STATUS    8'h04
`define UET_OFS_TXDATA    8'h08
`define UET_OFS_BAUD      8'h0C
// ************************************************************
// Line mode register fields
// ************************************************************
`define UET_MODE_ON       15
`define UET_MODE_PDS_HI   2
`define UET_MODE_PDS_LO   1
`define UET_MODE_STOP     0
// ************************************************************
// Line status register fields
// ************************************************************
`define UET_STA_TXISEL    15
`define UET_STA_BREAK     11
`define UET_STA_TXEN      10
`define UET_STA_FULL      9
`define UET_STA_SHIFT_EMPTY_FLAG      8
`define UET_STA_RXI_HI    7
`define UET_STA_RXI_LO    6
`define UET_STA_ADDR      5
`define UET_STA_RECEIVER_IDLE_FLAG     4
// ************************************************************
// Format codes and reset values
// ************************************************************
`define UET_PDS_8N        2'h0
`define UET_PDS_8E        2'h1
`define UET_PDS_8O        2'h2
`define UET_PDS_9N        2'h3
`define UET_RST_PDS       2'h0
`define UET_RST_STOP      1'h0
`define UET_RST_BAUD      16'h0000
// ************************************************************
// Sizes and counts
// ************************************************************
`define UET_FIFO_DEPTH    3'h4
`define UET_OVERSAMPLE    4'hF
`define UET_LEN_BASE      4'hA
`endif

// file: src/uet_uart.v
// What this block does
// - Module on makes the out pin an output and in pin an input.
// - Enabled and idle, the serial output stays high.
// - Off after reset; pins then follow port latch and direction inputs.
// - Turning off empties buffers and resets the baud counter.
// - Turning off clears break and transmit enable, keeps mode, divisor and other status bits.
// - Turning off aborts transfers; turning on resumes with kept settings.
// - Two-bit format field: 8 none, 8 even, 8 odd, 9 none.
// - One or two stop bits per character by stop count select.
// - Reset format is eight data bits, no parity, one stop.
// - Transmission only happens while transmit enable is set.
// - Written character moves to free shifter at once; output at next baud edge.
// - Character loaded while disabled starts at once when enable set.
// - Holding FIFO is 9 bits wide, 4 deep, plus shifter.
// - Status bit 9 shows the FIFO full.
// - Writes to a full FIFO are dropped; contents stay intact.
// - FIFO cleared by reset and by turning the module off.
// - Transmit flag pulses per move, or only on moves leaving FIFO empty.
// - Break send forces the output low over everything else.
// - Break never pulses the transmit flag.
// - Bit rate is clock over sixteen times divisor plus one.
//
// Our own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "uet_uart_regs.vh"

module uet_uart (
  // Clock, reset, enable
  input  wire        clk,
  input  wire        rst,
  input  wire        ce,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Port settings used while the module is off
  input  wire        port_out_latch,
  input  wire        port_out_dir_in,
  input  wire        port_in_latch,
  input  wire        port_in_dir_in,
  // Serial pins
  output reg         serial_out_pin_o,
  output reg         serial_out_pin_oe,
  output reg         serial_in_pin_o,
  output reg         serial_in_pin_oe,
  // Transmit event
  output reg         tx_irq_flag
);

  // ************************************************************
  // Helper functions
  // ************************************************************
  function [3:0] frame_len;
    input [1:0] pds;
    input       two_stop;
    begin
      frame_len = `UET_LEN_BASE + {3'h0, (pds != `UET_PDS_8N)} + {3'h0, two_stop};
    end
  endfunction

  function [11:0] frame_bits;
    input [1:0] pds;
    input [8:0] data;
    reg         ninth;
    begin
      ninth = 1'b1;
      case (pds)
        `UET_PDS_8E: ninth = ^data[7:0];
        `UET_PDS_8O: ninth = ~^data[7:0];
        `UET_PDS_9N: ninth = data[8];
        default:     ninth = 1'b1;
      endcase
      frame_bits = {2'h3, ninth, data[7:0], 1'b0};
    end
  endfunction

  function [1:0] ptr_inc;
    input [1:0] ptr;
    begin
      ptr_inc = ptr + 2'h1;
    end
  endfunction

  function [3:0] reg_select;
    input [7:0] adr;
    begin
      if (adr == `UET_OFS_MODE) begin
        reg_select = 4'h1;
      end else if (adr == `UET_OFS_STATUS) begin
        reg_select = 4'h2;
      end else if (adr == `UET_OFS_TXDATA) begin
        reg_select = 4'h4;
      end else if (adr == `UET_OFS_BAUD) begin
        reg_select = 4'h8;
      end else begin
        reg_select = 4'h0;
      end
    end
  endfunction

  // ************************************************************
  // Registers
  // ************************************************************
  reg         on_reg;
  reg [1:0]   pds_reg;
  reg         stop_reg;
  reg         txisel_reg;
  reg         brk_reg;
  reg         txen_reg;
  reg [1:0]   rxisel_reg;
  reg         addr_reg;
  reg [15:0]  baud_reg;
  reg [8:0]   fifo_mem [0:3];
  reg [1:0]   wr_ptr_reg;
  reg [1:0]   rd_ptr_reg;
  reg [2:0]   count_reg;
  reg [11:0]  shift_reg;
  reg [3:0]   bits_reg;
  reg         last_reg;
  reg         line_reg;
  reg [15:0]  div_cnt_reg;
  reg [3:0]   sub_cnt_reg;

  wire        bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        bus_wr    = bus_req & wb_we_i;
  wire [3:0]  hit       = reg_select(wb_adr_i);
  wire        fifo_full = (count_reg == `UET_FIFO_DEPTH);
  wire        tick      = (div_cnt_reg == 16'h0000) && (sub_cnt_reg == 4'h0);
  wire        running   = on_reg & txen_reg;
  wire        push      = bus_wr && hit[2] && wb_sel_i[0] && !fifo_full;
  wire [8:0]  push_word = {wb_sel_i[1] & wb_dat_i[8], wb_dat_i[7:0]};
  wire        move      = running && (bits_reg == 4'h0) && (count_reg != 3'h0);
  wire        shift_empty_flag      = (bits_reg == 4'h0) && !last_reg;
  wire [8:0]  head      = fifo_mem[rd_ptr_reg];
  wire [11:0] next_frame = frame_bits(pds_reg, head);
  wire [3:0]  next_len  = frame_len(pds_reg, stop_reg);
  wire        leaves_empty = (count_reg == 3'h1) && !push;

  // ************************************************************
  // Status word
  // ************************************************************
  reg [15:0]  status_word;
  always @* begin
    status_word = 16'h0000;
    status_word[`UET_STA_TXISEL] = txisel_reg;
    status_word[`UET_STA_BREAK] = brk_reg;
    status_word[`UET_STA_TXEN] = txen_reg;
    status_word[`UET_STA_FULL] = fifo_full;
    status_word[`UET_STA_SHIFT_EMPTY_FLAG] = shift_empty_flag;
    status_word[`UET_STA_RXI_HI:`UET_STA_RXI_LO] = rxisel_reg;
    status_word[`UET_STA_ADDR] = addr_reg;
    status_word[`UET_STA_RECEIVER_IDLE_FLAG] = 1'b1;
  end

  // ************************************************************
  // Read data
  // ************************************************************
  reg [31:0]  rd_word;
  always @* begin
    rd_word = 32'h00000000;
    if (hit[0]) begin
      rd_word = {16'h0000, on_reg, 12'h000, pds_reg, stop_reg};
    end else if (hit[1]) begin
      rd_word = {16'h0000, status_word};
    end else if (hit[3]) begin
      rd_word = {16'h0000, baud_reg};
    end
  end

  // ************************************************************
  // Wishbone answer
  // ************************************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else if (ce) begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        wb_dat_o <= rd_word;
      end
    end
  end

  // ************************************************************
  // Control registers
  // ************************************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      on_reg     <= 1'b0;
      pds_reg    <= `UET_RST_PDS;
      stop_reg   <= `UET_RST_STOP;
      txisel_reg <= 1'b0;
      brk_reg    <= 1'b0;
      txen_reg   <= 1'b0;
      rxisel_reg <= 2'h0;
      addr_reg   <= 1'b0;
      baud_reg   <= `UET_RST_BAUD;
    end else if (ce) begin
      if (bus_wr) begin
        if (hit[0]) begin
          if (wb_sel_i[0]) begin
            pds_reg  <= wb_dat_i[`UET_MODE_PDS_HI:`UET_MODE_PDS_LO];
            stop_reg <= wb_dat_i[`UET_MODE_STOP];
          end
          if (wb_sel_i[1]) begin
            on_reg <= wb_dat_i[`UET_MODE_ON];
          end
        end else if (hit[1]) begin
          if (wb_sel_i[0]) begin
            rxisel_reg <= wb_dat_i[`UET_STA_RXI_HI:`UET_STA_RXI_LO];
            addr_reg   <= wb_dat_i[`UET_STA_ADDR];
          end
          if (wb_sel_i[1]) begin
            txisel_reg <= wb_dat_i[`UET_STA_TXISEL];
            brk_reg    <= wb_dat_i[`UET_STA_BREAK] & on_reg;
            txen_reg   <= wb_dat_i[`UET_STA_TXEN] & on_reg;
          end
        end else if (hit[3]) begin
          if (wb_sel_i[0]) begin
            baud_reg[7:0] <= wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            baud_reg[15:8] <= wb_dat_i[15:8];
          end
        end
      end
      if (!on_reg) begin
        brk_reg  <= 1'b0;
        txen_reg <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Baud divider
  // ************************************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt_reg <= 16'h0000;
      sub_cnt_reg <= 4'h0;
    end else if (ce) begin
      if (!running) begin
        div_cnt_reg <= 16'h0000;
        sub_cnt_reg <= 4'h0;
      end else if (div_cnt_reg == baud_reg) begin
        div_cnt_reg <= 16'h0000;
        sub_cnt_reg <= sub_cnt_reg + 4'h1;
      end else begin
        div_cnt_reg <= div_cnt_reg + 16'h0001;
      end
    end
  end

  // ************************************************************
  // Holding FIFO
  // ************************************************************
  always @(posedge clk) begin
    if (ce && push) begin
      fifo_mem[wr_ptr_reg] <= push_word;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= 2'h0;
      rd_ptr_reg <= 2'h0;
      count_reg  <= 3'h0;
    end else if (ce) begin
      if (!on_reg) begin
        wr_ptr_reg <= 2'h0;
        rd_ptr_reg <= 2'h0;
        count_reg  <= 3'h0;
      end else begin
        if (push) begin
          wr_ptr_reg <= ptr_inc(wr_ptr_reg);
        end
        if (move) begin
          rd_ptr_reg <= ptr_inc(rd_ptr_reg);
        end
        if (push && !move) begin
          count_reg <= count_reg + 3'h1;
        end else if (move && !push) begin
          count_reg <= count_reg - 3'h1;
        end
      end
    end
  end

  // ************************************************************
  // Shifter
  // ************************************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_reg   <= 12'hFFF;
      bits_reg    <= 4'h0;
      last_reg    <= 1'b0;
      line_reg    <= 1'b1;
    end else if (ce) begin
      if (!running) begin
        if (!on_reg) begin
          shift_reg <= 12'hFFF;
          bits_reg  <= 4'h0;
          last_reg  <= 1'b0;
        end
        line_reg <= 1'b1;
      end else if (move) begin
        if (tick) begin
          line_reg  <= 1'b0;
          shift_reg <= {1'b1, next_frame[11:1]};
          bits_reg  <= next_len - 4'h1;
        end else begin
          shift_reg <= next_frame;
          bits_reg  <= next_len;
        end
      end else if (tick) begin
        if (bits_reg != 4'h0) begin
          line_reg  <= shift_reg[0];
          shift_reg <= {1'b1, shift_reg[11:1]};
          bits_reg  <= bits_reg - 4'h1;
          last_reg  <= (bits_reg == 4'h1);
        end else begin
          line_reg <= 1'b1;
          last_reg <= 1'b0;
        end
      end
    end
  end

  // ************************************************************
  // Transmit event
  // ************************************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_irq_flag <= 1'b0;
    end else if (ce) begin
      tx_irq_flag <= move && (!txisel_reg || leaves_empty);
    end
  end

  // ************************************************************
  // Pin multiplexing
  // ************************************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      serial_out_pin_o  <= 1'b0;
      serial_out_pin_oe <= 1'b0;
      serial_in_pin_o   <= 1'b0;
      serial_in_pin_oe  <= 1'b0;
    end else if (ce) begin
      if (on_reg) begin
        serial_out_pin_o  <= line_reg & ~brk_reg;
        serial_out_pin_oe <= 1'b1;
        serial_in_pin_o   <= 1'b0;
        serial_in_pin_oe  <= 1'b0;
      end else begin
        serial_out_pin_o  <= port_out_latch;
        serial_out_pin_oe <= ~port_out_dir_in;
        serial_in_pin_o   <= port_in_latch;
        serial_in_pin_oe  <= ~port_in_dir_in;
      end
    end
  end

endmodule
`default_nettype wire

// file: verif/uet_uart_checker.sv
`timescale 1ns/1ps
`default_nettype none
module uet_uart_checker (
  // Clock, reset, enable
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        ce,
  // Wishbone
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Port settings and pins
  input wire logic        port_out_latch,
  input wire logic        port_out_dir_in,
  input wire logic        port_in_latch,
  input wire logic        port_in_dir_in,
  input wire logic        serial_out_pin_o,
  input wire logic        serial_out_pin_oe,
  input wire logic        serial_in_pin_o,
  input wire logic        serial_in_pin_oe,
  input wire logic        tx_irq_flag
);
  logic rdy_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) rdy_reg <= 1'b0;
    else rdy_reg <= 1'b1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  ack_answer_a: assert property (ce && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked in one cycle");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  dat_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read data not zero");
  unmapped_read_a: assert property (wb_ack_o && $past(wb_adr_i) == 8'h10 && !$past(wb_we_i)
    |-> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
  irq_pulse_a: assert property (tx_irq_flag |=> !tx_irq_flag) else $error("irq not a pulse");
  on_in_pin_a: assert property (rdy_reg && $past(port_out_dir_in) && serial_out_pin_oe
    |-> !serial_in_pin_oe) else $error("in pin driven while on");
  on_out_pin_a: assert property (rdy_reg && !$past(port_in_dir_in) && !serial_in_pin_oe
    |-> serial_out_pin_oe) else $error("out pin not driven while on");
  off_port_pins_a: assert property (rdy_reg && serial_in_pin_oe
    |-> serial_out_pin_o == $past(port_out_latch) && serial_out_pin_oe == !$past(port_out_dir_in)
    && serial_in_pin_o == $past(port_in_latch)) else $error("off pins not from port");
endmodule
bind uet_uart uet_uart_checker u_chk (.*);
`default_nettype wire

// file: verif/uet_line_rx.sv
`timescale 1ns/1ps
`default_nettype none
module uet_line_rx (
  // Clock and line
  input wire logic        clk,
  input wire logic        line_o,
  input wire logic        line_oe,
  // Format
  input wire logic [15:0] bit_cyc,
  input wire logic [3:0]  nbits,
  input wire logic [1:0]  nstop,
  // Result
  output var logic [8:0]  data,
  output var logic        stop_ok,
  output var logic [7:0]  n_frames
);
  // Released line is pulled up
  wire logic line = line_oe ? line_o : 1'b1;
  initial begin
    data = 9'h000;
    stop_ok = 1'b0;
    n_frames = 8'h00;
    forever begin
      @(negedge line);
      repeat (bit_cyc / 2) @(posedge clk);
      data = 9'h000;
      for (int i = 0; i < nbits; i++) begin
        repeat (bit_cyc) @(posedge clk);
        data[i] = line;
      end
      stop_ok = 1'b1;
      for (int i = 0; i < nstop; i++) begin
        repeat (bit_cyc) @(posedge clk);
        stop_ok = stop_ok & line;
      end
      n_frames = n_frames + 8'h01;
    end
  end
endmodule
`default_nettype wire

// file: verif/uet_uart_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "uet_uart_regs.vh"
module uet_uart_tb;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, v;
  logic [15:0] bit_cyc = 16'h0010;
  logic [3:0] nbits = 4'h8;
  logic [1:0] nstop = 2'h1;
  wire logic [31:0] wb_dat_o;
  wire logic wb_ack_o, so_o, so_oe, si_o, si_oe, tx_irq_flag, rx_stop;
  wire logic [8:0] rx_data;
  wire logic [7:0] rx_n;
  int failures = 0, n_checks = 0, n_irq = 0;
  uet_uart dut (.clk(clk), .rst(rst), .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .port_out_latch(1'b1), .port_out_dir_in(1'b1), .port_in_latch(1'b0), .port_in_dir_in(1'b0),
    .serial_out_pin_o(so_o), .serial_out_pin_oe(so_oe), .serial_in_pin_o(si_o),
    .serial_in_pin_oe(si_oe), .tx_irq_flag(tx_irq_flag));
  uet_line_rx rx (.clk(clk), .line_o(so_o), .line_oe(so_oe), .bit_cyc(bit_cyc), .nbits(nbits),
    .nstop(nstop), .data(rx_data), .stop_ok(rx_stop), .n_frames(rx_n));
  initial forever #25 clk = ~clk;
  always @(posedge clk) if (tx_irq_flag === 1'b1) n_irq++;
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= {16'h0, d}; sel <= s;
    do begin @(posedge clk); k++; end while (wb_ack_o !== 1'b1 && k < 100);
    if (wb_ack_o !== 1'b1) begin
      failures++;
      $display("MISMATCH bus ack expected 1 seen %b", wb_ack_o);
    end
    v = wb_dat_o;
    cyc <= 0; stb <= 0; we <= 0;
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d); bus(1, a, d, 4'h3); endtask
  task rd(input logic [7:0] a); bus(0, a, 16'h0, 4'h3); endtask
  task wait_rx(input int n);
    int k;
    k = 0;
    while (rx_n < n && k < 4000) begin @(posedge clk); k++; end
    if (rx_n < n) begin
      failures++;
      $display("MISMATCH frame count expected %0d seen %0d", n, rx_n);
    end
  endtask
  task t_reset;
    rd(`UET_OFS_MODE); chk("mode", 32'h0, v);
    rd(`UET_OFS_STATUS); chk("status", 32'h0110, v);
    rd(8'h10); chk("unmapped", 32'h0, v);
    $display("test reset done");
  endtask
  task t_format;
    logic [8:0] d, e;
    for (int f = 0; f < 4; f++) begin
      bit_cyc = 16 * (f % 2 + 1); nbits = (f == 0) ? 8 : 9; nstop = f / 2 + 1;
      wr(`UET_OFS_BAUD, f % 2);
      wr(`UET_OFS_MODE, 16'h8000 | (f << 1) | (f / 2));
      wr(`UET_OFS_STATUS, 16'h0400);
      d = (f == 3) ? 9'h1A5 : 9'h0A5;
      e = (f == 1) ? {^d[7:0], d[7:0]} : (f == 2) ? {~^d[7:0], d[7:0]} : d;
      wr(`UET_OFS_TXDATA, d); wait_rx(rx_n + 1);
      chk("frame data", e, rx_data);
      chk("stop bits", 1, rx_stop);
      wr(`UET_OFS_MODE, 16'h0000);
    end
    $display("test format done");
  endtask
  task t_fifo;
    int c, i0;
    nbits = 8; nstop = 1;
    for (int s = 0; s < 2; s++) begin
      wr(`UET_OFS_MODE, 16'h8000); wr(`UET_OFS_STATUS, s << 15);
      for (int k = 0; k < 5; k++) wr(`UET_OFS_TXDATA, 16'h30 + k);
      rd(`UET_OFS_STATUS); chk("full flag", 1, v[9]);
      c = rx_n; i0 = n_irq; repeat (400) @(posedge clk);
      chk("no tx while disabled", c, rx_n);
      wr(`UET_OFS_STATUS, (s << 15) | 16'h0400);
      repeat (3) @(posedge clk);
      chk("start at once", 0, so_o);
      for (int k = 0; k < 4; k++) begin
        wait_rx(c + k + 1); chk("fifo order", 16'h30 + k, rx_data);
      end
      repeat (700) @(posedge clk);
      chk("fifo depth", c + 4, rx_n);
      chk("irq count", s ? 1 : 4, n_irq - i0);
      wr(`UET_OFS_MODE, 16'h0000);
    end
    $display("test fifo done");
  endtask
  task t_break;
    int i0, hi;
    hi = 0;
    wr(`UET_OFS_MODE, 16'h8000); i0 = n_irq;
    wr(`UET_OFS_STATUS, 16'h0C00);
    repeat (13 * 32) begin @(posedge clk); if (so_o !== 1'b0) hi++; end
    chk("break low", 0, hi);
    wr(`UET_OFS_STATUS, 16'h0400); repeat (64) @(posedge clk);
    chk("idle high", 1, so_o);
    chk("break irq", 0, n_irq - i0);
    $display("test break done");
  endtask
  task t_off;
    int c;
    wr(`UET_OFS_STATUS, 16'h8C00); wr(`UET_OFS_TXDATA, 16'h5A);
    repeat (100) @(posedge clk);
    wr(`UET_OFS_MODE, 16'h0000);
    rd(`UET_OFS_STATUS); chk("off status", 32'h8110, v);
    rd(`UET_OFS_BAUD); chk("off divisor", 32'h1, v);
    repeat (700) @(posedge clk); c = rx_n;
    wr(`UET_OFS_MODE, 16'h8000); repeat (400) @(posedge clk);
    chk("nothing resent", c, rx_n);
    wr(`UET_OFS_STATUS, 16'h0400); wr(`UET_OFS_TXDATA, 16'h3C); wait_rx(c + 1);
    chk("resumed frame", 16'h3C, rx_data);
    $display("test off done");
  endtask
  task summarize;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #1000000;
    failures++;
    summarize;
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    t_reset; t_format; t_fifo; t_break; t_off;
    summarize;
  end
endmodule
`default_nettype wire
